// ---- rtl/lane_error_counter_hold_cfg.sv ----
// How it works
// - With a hold bit set, its counter stops at 0xFF and stays there until cleared.
// - With a hold bit clear, its counter rolls from its top value back to zero.
// - In each hold field bit 2 is control char, bit 1 invalid group, bit 0 disparity.
// - Each hold field resets to 0x7 and the reserved bits 7:3 read as zero.
// - Lanes 3, 4 and 5 each own one register at 0x48B, 0x48C and 0x48D.
// - A per-lane clear field with the same bit order zeroes the chosen counters, or loads 1 where an error comes in the same cycle.
// - A terminal flag goes to 1 when its counter reaches 0xFF.
`timescale 1ns/1ns
`include "lane_err_hold_params.svh"

module lane_error_counter_hold_cfg (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire lane_err_pkg::addr_t cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire lane_err_pkg::data_t cfg_wdata_i,
  input wire logic cfg_rd_i,
  output lane_err_pkg::data_t cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic deframer_soft_reset_i,
  input wire lane_err_pkg::lane_vec_t unexpected_control_char_error_i,
  input wire lane_err_pkg::lane_vec_t invalid_code_group_error_i,
  input wire lane_err_pkg::lane_vec_t running_disparity_error_i,
  input wire lane_err_pkg::hold_t lane3_counter_clear_i,
  input wire lane_err_pkg::hold_t lane4_counter_clear_i,
  input wire lane_err_pkg::hold_t lane5_counter_clear_i,
  output lane_err_pkg::cnt_t [`LEH_CNTS-1:0] err_count_o,
  output logic [`LEH_CNTS-1:0] terminal_reached_o
);
  import lane_err_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  logic sel_lane3;
  logic sel_lane4;
  logic sel_lane5;
  logic sel_any;
  logic wr_lane3;
  logic wr_lane4;
  logic wr_lane5;
  hold_t wr_field;
  hold_t rd_field;
  data_t cfg_rdata_nxt;

  assign sel_lane3 = (cfg_addr_i == `LEH_ADDR_LANE3);
  assign sel_lane4 = (cfg_addr_i == `LEH_ADDR_LANE4);
  assign sel_lane5 = (cfg_addr_i == `LEH_ADDR_LANE5);
  assign sel_any = sel_lane3 | sel_lane4 | sel_lane5;
  // Writes taken at any time; software keeps them to soft reset
  assign wr_lane3 = cfg_wr_i & sel_lane3;
  assign wr_lane4 = cfg_wr_i & sel_lane4;
  assign wr_lane5 = cfg_wr_i & sel_lane5;
  assign wr_field = cfg_wdata_i[`LEH_FIELD_MSB:0];

  // ****************************************
  // Hold configuration registers
  // ****************************************
  hold_t lane3_err_cnt_saturate_cfg_r;
  hold_t lane4_err_cnt_saturate_cfg_r;
  hold_t lane5_err_cnt_saturate_cfg_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lane3_err_cnt_saturate_cfg_r <= `LEH_HOLD_RESET;
      lane4_err_cnt_saturate_cfg_r <= `LEH_HOLD_RESET;
      lane5_err_cnt_saturate_cfg_r <= `LEH_HOLD_RESET;
    end else begin
      if (wr_lane3) begin
        lane3_err_cnt_saturate_cfg_r <= wr_field;
      end
      if (wr_lane4) begin
        lane4_err_cnt_saturate_cfg_r <= wr_field;
      end
      if (wr_lane5) begin
        lane5_err_cnt_saturate_cfg_r <= wr_field;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  data_t cfg_rdata_r;
  logic cfg_rvalid_r;

  assign rd_field = sel_lane3 ? lane3_err_cnt_saturate_cfg_r :
                    sel_lane4 ? lane4_err_cnt_saturate_cfg_r :
                    sel_lane5 ? lane5_err_cnt_saturate_cfg_r : `LEH_HOLD_RESET;
  assign cfg_rdata_nxt = sel_any ? {`LEH_RSVD_ZERO, rd_field} : `LEH_UNMAPPED_DATA;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_rdata_r <= `LEH_UNMAPPED_DATA;
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rvalid_r <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_r <= cfg_rdata_nxt;
      end
    end
  end

  assign cfg_rdata_o = cfg_rdata_r;
  assign cfg_rvalid_o = cfg_rvalid_r;

  // ****************************************
  // Per-lane grouping
  // ****************************************
  hold_t hold_q [`LEH_LANES];
  hold_t clr_q [`LEH_LANES];
  hold_t evt_q [`LEH_LANES];

  assign hold_q[0] = lane3_err_cnt_saturate_cfg_r;
  assign hold_q[1] = lane4_err_cnt_saturate_cfg_r;
  assign hold_q[2] = lane5_err_cnt_saturate_cfg_r;
  assign clr_q[0] = lane3_counter_clear_i;
  assign clr_q[1] = lane4_counter_clear_i;
  assign clr_q[2] = lane5_counter_clear_i;

  // ****************************************
  // Error counters
  // ****************************************
  for (genvar l = 0; l < `LEH_LANES; l++) begin : g_lane
    assign evt_q[l][`LEH_BIT_UCC] = unexpected_control_char_error_i[l];
    assign evt_q[l][`LEH_BIT_ICG] = invalid_code_group_error_i[l];
    assign evt_q[l][`LEH_BIT_RD] = running_disparity_error_i[l];
    for (genvar k = 0; k < `LEH_KINDS; k++) begin : g_kind
      localparam int IX = l * `LEH_KINDS + k;
      // Hold bits act live on the counters
      err_count_cell u_cell (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .hold_i(hold_q[l][k]),
        .clear_i(clr_q[l][k]),
        .event_i(evt_q[l][k]),
        .count_o(err_count_o[IX]),
        .reached_o(terminal_reached_o[IX])
      );
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  for (genvar l = 0; l < `LEH_LANES; l++) begin : g_chk_lane
    for (genvar k = 0; k < `LEH_KINDS; k++) begin : g_chk_kind
      localparam int IX = l * `LEH_KINDS + k;
      hold_sat_a: assert property (
        hold_q[l][k] && !clr_q[l][k] && err_count_o[IX] == `LEH_CNT_TERMINAL
        |=> err_count_o[IX] == `LEH_CNT_TERMINAL)
        else $error("held counter left terminal value");
      wrap_zero_a: assert property (
        !hold_q[l][k] && !clr_q[l][k] && evt_q[l][k]
        && err_count_o[IX] == `LEH_CNT_TERMINAL
        |=> err_count_o[IX] == `LEH_CNT_ZERO)
        else $error("free counter did not wrap to zero");
      count_up_a: assert property (
        !clr_q[l][k] && evt_q[l][k] && err_count_o[IX] != `LEH_CNT_TERMINAL
        |=> err_count_o[IX] == $past(err_count_o[IX]) + `LEH_CNT_STEP)
        else $error("counter did not step by one");
      count_idle_a: assert property (
        (!clr_q[l][k] && !evt_q[l][k])[*2]
        |-> err_count_o[IX] == $past(err_count_o[IX]))
        else $error("counter moved with no error");
      clear_cnt_a: assert property (
        clr_q[l][k] |=> err_count_o[IX] ==
        ($past(evt_q[l][k]) ? `LEH_CNT_ONE : `LEH_CNT_ZERO))
        else $error("clear did not reset counter");
      flag_set_a: assert property (
        err_count_o[IX] == `LEH_CNT_TERMINAL |-> terminal_reached_o[IX])
        else $error("terminal flag missing at 0xFF");
      flag_keep_a: assert property (
        terminal_reached_o[IX] && !clr_q[l][k] |=> terminal_reached_o[IX])
        else $error("terminal flag dropped without clear");
    end
  end

  bit_order_a: assert property (
    lane3_err_cnt_saturate_cfg_r == 3'h4 && !lane3_counter_clear_i[`LEH_BIT_RD]
    && err_count_o[`LEH_BIT_RD] == `LEH_CNT_TERMINAL && running_disparity_error_i[0]
    |=> err_count_o[`LEH_BIT_RD] == `LEH_CNT_ZERO)
    else $error("disparity counter follows wrong hold bit");

  reset_value_a: assert property (
    $past(!rst_n_i) |-> lane3_err_cnt_saturate_cfg_r == `LEH_HOLD_RESET
    && lane4_err_cnt_saturate_cfg_r == `LEH_HOLD_RESET
    && lane5_err_cnt_saturate_cfg_r == `LEH_HOLD_RESET)
    else $error("hold field not 0x7 after reset");

  rsvd_zero_a: assert property (
    cfg_rvalid_o |-> cfg_rdata_o[7:3] == `LEH_RSVD_ZERO)
    else $error("reserved bits read nonzero");

  read_back_a: assert property (
    cfg_rd_i && cfg_addr_i == `LEH_ADDR_LANE4
    |=> cfg_rvalid_o && cfg_rdata_o == {`LEH_RSVD_ZERO, $past(lane4_err_cnt_saturate_cfg_r)})
    else $error("lane 4 register read wrong");

  write_take_a: assert property (
    cfg_wr_i && cfg_addr_i == `LEH_ADDR_LANE5
    |=> lane5_err_cnt_saturate_cfg_r == $past(cfg_wdata_i[`LEH_FIELD_MSB:0])
    && $stable(lane3_err_cnt_saturate_cfg_r))
    else $error("lane 5 write missed or spilled");

  rvalid_pulse_a: assert property (
    !cfg_rd_i |=> !cfg_rvalid_o)
    else $error("read valid stood without a read");

  unmapped_read_a: assert property (
    cfg_rd_i && !sel_any |=> cfg_rvalid_o && cfg_rdata_o == `LEH_UNMAPPED_DATA)
    else $error("unmapped read returned nonzero");

  sat_seen_c: cover property (
    hold_q[0][0] && err_count_o[0] == `LEH_CNT_TERMINAL && evt_q[0][0]);
  wrap_seen_c: cover property (
    !hold_q[1][2] && err_count_o[5] == `LEH_CNT_TERMINAL && evt_q[1][2]);
  write_reset_c: cover property (cfg_wr_i && sel_any && deframer_soft_reset_i);
  read_seen_c: cover property (cfg_rd_i && sel_lane3 ##1 cfg_rvalid_o);
endmodule : lane_error_counter_hold_cfg

// ---- rtl/lane_err_hold_params.svh ----
`ifndef LANE_ERR_HOLD_PARAMS_SVH
`define LANE_ERR_HOLD_PARAMS_SVH

// ****************************************
// Lane and counter counts
// ****************************************
`define LEH_LANES 3
`define LEH_KINDS 3
`define LEH_CNTS 9

// ****************************************
// Register addresses
// ****************************************
`define LEH_ADDR_LANE3 12'h48B
`define LEH_ADDR_LANE4 12'h48C
`define LEH_ADDR_LANE5 12'h48D

// ****************************************
// Field layout and reset values
// ****************************************
`define LEH_HOLD_RESET 3'h7
`define LEH_RSVD_ZERO 5'h00
`define LEH_UNMAPPED_DATA 8'h00
`define LEH_FIELD_MSB 2
`define LEH_BIT_UCC 2
`define LEH_BIT_ICG 1
`define LEH_BIT_RD 0

// ****************************************
// Counter values
// ****************************************
`define LEH_CNT_TERMINAL 8'hFF
`define LEH_CNT_ZERO 8'h00
`define LEH_CNT_ONE 8'h01
`define LEH_CNT_STEP 8'h01

`endif

// ---- rtl/lane_err_pkg.sv ----
package lane_err_pkg;
  typedef logic [11:0] addr_t;
  typedef logic [7:0] data_t;
  typedef logic [7:0] cnt_t;
  typedef logic [2:0] hold_t;
  typedef logic [2:0] lane_vec_t;
endpackage : lane_err_pkg

// ---- rtl/err_count_cell.sv ----
`timescale 1ns/1ns
`include "lane_err_hold_params.svh"

module err_count_cell (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hold_i,
  input wire logic clear_i,
  input wire logic event_i,
  output lane_err_pkg::cnt_t count_o,
  output logic reached_o
);
  import lane_err_pkg::*;

  // ****************************************
  // Next state
  // ****************************************
  cnt_t count_r;
  cnt_t count_nxt;
  cnt_t count_inc;
  cnt_t count_cleared;
  logic reached_r;
  logic reached_nxt;
  logic at_terminal;
  logic step;

  assign at_terminal = (count_r == `LEH_CNT_TERMINAL);
  assign step = event_i & ~(hold_i & at_terminal);
  assign count_inc = count_r + `LEH_CNT_STEP;
  assign count_cleared = event_i ? `LEH_CNT_ONE : `LEH_CNT_ZERO;
  assign count_nxt = clear_i ? count_cleared : (step ? count_inc : count_r);
  assign reached_nxt = (count_nxt == `LEH_CNT_TERMINAL) | (reached_r & ~clear_i);

  // ****************************************
  // Flops
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_r <= `LEH_CNT_ZERO;
      reached_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      reached_r <= reached_nxt;
    end
  end

  assign count_o = count_r;
  assign reached_o = reached_r;
endmodule : err_count_cell

// ---- testbench/err_event_source.sv ----
`timescale 1ns/1ns
// ****************************************
// Link transmitter error event source
// ****************************************
module err_event_source (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [1:0] lane_i,
  input wire logic [1:0] kind_i,
  input wire logic [8:0] n_i,
  output lane_err_pkg::lane_vec_t ucc_o,
  output lane_err_pkg::lane_vec_t icg_o,
  output lane_err_pkg::lane_vec_t rde_o,
  output logic busy_o
);
  import lane_err_pkg::*;
  logic [8:0] left_r = 9'h000;
  lane_vec_t sel;
  // One flagged code group per cycle on one lane and kind
  assign busy_o = (left_r != 9'h000);
  assign sel = busy_o ? (3'h1 << lane_i) : 3'h0;
  assign ucc_o = (kind_i == 2'h2) ? sel : 3'h0;
  assign icg_o = (kind_i == 2'h1) ? sel : 3'h0;
  assign rde_o = (kind_i == 2'h0) ? sel : 3'h0;
  always @(negedge clk_i) begin
    if (start_i) left_r <= n_i;
    else if (busy_o) left_r <= left_r - 9'h001;
  end
endmodule : err_event_source

// ---- testbench/lane_error_counter_hold_cfg_tb.sv ----
`timescale 1ns/1ns
module lane_error_counter_hold_cfg_tb;
  import lane_err_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  addr_t addr = 12'h000;
  data_t wdata = 8'h00;
  data_t rdata;
  logic wr = 1'b0, rd = 1'b0, sr = 1'b1, start = 1'b0, rvalid, busy;
  logic [1:0] lane = 2'h0, kind = 2'h0;
  logic [8:0] clr = 9'h000, n = 9'h000, flag;
  lane_vec_t ucc, icg, rde;
  cnt_t [8:0] cnt;
  logic [15:0] seed = 16'hA772;
  hold_t h;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  // ****************************************
  // Instances
  // ****************************************
  lane_error_counter_hold_cfg dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_addr_i(addr),
    .cfg_wr_i(wr), .cfg_wdata_i(wdata), .cfg_rd_i(rd), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .deframer_soft_reset_i(sr), .unexpected_control_char_error_i(ucc),
    .invalid_code_group_error_i(icg), .running_disparity_error_i(rde),
    .lane3_counter_clear_i(clr[2:0]), .lane4_counter_clear_i(clr[5:3]),
    .lane5_counter_clear_i(clr[8:6]), .err_count_o(cnt), .terminal_reached_o(flag));
  err_event_source src (.clk_i(clk_i), .start_i(start), .lane_i(lane), .kind_i(kind),
    .n_i(n), .ucc_o(ucc), .icg_o(icg), .rde_o(rde), .busy_o(busy));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic cnt_t exp_cnt(input logic hold, input logic [8:0] k);
    if (hold && k >= 9'h0FF) return 8'hFF;
    return k[7:0];
  endfunction : exp_cnt
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wr_reg(input addr_t a, input data_t d);
    @(negedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(negedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input addr_t a, input data_t e);
    @(negedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(negedge clk_i);
    rd <= 1'b0;
    check(rvalid === 1'b1 && rdata === e, "read data");
  endtask : rd_chk
  task automatic pulse_clr(input logic [8:0] m);
    @(negedge clk_i);
    clr <= m;
    @(negedge clk_i);
    clr <= 9'h000;
  endtask : pulse_clr
  task automatic run_case(input int c, input hold_t hv, input logic [4:0] up,
    input logic [8:0] nn);
    sr <= 1'b1;
    wr_reg(12'h48B + 12'(c / 3), {up, hv});
    rd_chk(12'h48B + 12'(c / 3), {5'h00, hv});
    pulse_clr(9'h1FF);
    sr <= 1'b0;
    n <= nn;
    lane <= 2'(c / 3);
    kind <= 2'(c % 3);
    start <= 1'b1;
    @(negedge clk_i);
    start <= 1'b0;
    @(negedge clk_i);
    for (int w = 0; w < 300 && busy === 1'b1; w++) @(negedge clk_i);
    for (int j = 0; j < 9; j++) begin
      check(cnt[j] === ((j == c) ? exp_cnt(hv[c % 3], nn) : 8'h00), "count");
      check(flag[j] === (j == c), "terminal flag");
    end
    pulse_clr(9'h001 << c);
    check(cnt[c] === 8'h00 && flag[c] === 1'b0, "clear");
  endtask : run_case
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i <= 1'b1;
    for (int l = 0; l < 3; l++) rd_chk(12'h48B + 12'(l), 8'h07);
    rd_chk(12'h48E, 8'h00);
    for (int i = 0; i < 18; i++) begin
      seed = lfsr(seed);
      h = seed[2:0];
      h[i % 3] = (i >= 9);
      run_case(i % 9, h, seed[7:3], 9'h0FF + 9'(seed[9:8] % 3));
    end
    run_case(0, 3'h4, 5'h1F, 9'h100);
    rst_n_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i <= 1'b1;
    for (int l = 0; l < 3; l++) rd_chk(12'h48B + 12'(l), 8'h07);
    give_verdict();
  end
endmodule : lane_error_counter_hold_cfg_tb
